/* core/bsr_status.sv */
// Bridge status register bank with Avalon-MM slave and interrupt logic
`timescale 1ns/10ps

module bsr_status
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Avalon-MM slave
  input wire logic [bsr_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Events from primary link and port logic
  input wire bsr_pkg::bsr_events_t EVENTS_I,
  // Forwarded downstream interrupts, deliberately unused
  input wire logic FWD_INTX_I,
  // Control levels and interrupt
  output logic PARITY_ERROR_ENABLE_O,
  output logic SYSTEM_ERROR_ENABLE_O,
  output logic IRQ_O
);

  bsr_pkg::bsr_state_t state;
  bsr_pkg::bsr_state_t next_state;
  logic wr_hit;
  logic rd_hit;
  logic [15:0] wmask;
  logic [15:0] status_view;
  logic int_pend;
  logic [bsr_pkg::IRQ_W-1:0] irq_set;
  logic [bsr_pkg::IRQ_W-1:0] irq_clr;
  bsr_pkg::bsr_flags_t set_f;
  bsr_pkg::bsr_flags_t clr_f;
  logic unused_fwd;

  // Byte enables widened to a bit mask over the low half-word
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // Sticky flag update: set wins over clear
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  assign unused_fwd = FWD_INTX_I;
  assign wmask = lane_mask(AVS_BYTEENABLE_I[1:0]);

  // Pending legacy interrupt from the bridge itself, chosen by port role
  always_comb
  begin
    if (state.control[bsr_pkg::POS_DOWNSTREAM_PORT])
    begin
      int_pend = EVENTS_I.hotplug_irq;
    end
    else
    begin
      int_pend = EVENTS_I.internal_parity_err | EVENTS_I.cfg_access_err;
    end
  end

  // Register view: constants give capability bit one and zeros elsewhere
  always_comb
  begin
    status_view = bsr_pkg::CONST_BRIDGE_STATUS;
    status_view[bsr_pkg::POS_INTERRUPT_PENDING] = state.int_pend_q;
    status_view[bsr_pkg::POS_MASTER_POISON] = state.flags.master_poison_flag;
    status_view[bsr_pkg::POS_SIGNALED_SYSTEM_ERROR] = state.flags.signaled_system_error;
    status_view[bsr_pkg::POS_DETECTED_POISON] = state.flags.detected_poison_flag;
  end

  always_comb
  begin
    next_state = state;
    wr_hit = AVS_WRITE_I & ~state.rvalid;
    rd_hit = AVS_READ_I & ~state.rvalid & ~AVS_WRITE_I;

    // Flag events
    set_f.master_poison_flag = state.control[bsr_pkg::POS_PARITY_ERROR_ENABLE]
      & (EVENTS_I.poisoned_cpl_rx | EVENTS_I.poisoned_wr_tx);
    set_f.signaled_system_error = state.control[bsr_pkg::POS_SYSTEM_ERROR_ENABLE]
      & EVENTS_I.err_msg_tx;
    set_f.detected_poison_flag = EVENTS_I.poisoned_tlp_rx;

    // Write-one-to-clear on the status register
    clr_f = '0;
    if (wr_hit && AVS_ADDRESS_I == bsr_pkg::ADDR_BRIDGE_STATUS)
    begin
      clr_f.master_poison_flag = AVS_WRITEDATA_I[bsr_pkg::POS_MASTER_POISON]
        & wmask[bsr_pkg::POS_MASTER_POISON];
      clr_f.signaled_system_error = AVS_WRITEDATA_I[bsr_pkg::POS_SIGNALED_SYSTEM_ERROR]
        & wmask[bsr_pkg::POS_SIGNALED_SYSTEM_ERROR];
      clr_f.detected_poison_flag = AVS_WRITEDATA_I[bsr_pkg::POS_DETECTED_POISON]
        & wmask[bsr_pkg::POS_DETECTED_POISON];
    end
    next_state.flags.master_poison_flag = sticky(state.flags.master_poison_flag,
      set_f.master_poison_flag, clr_f.master_poison_flag);
    next_state.flags.signaled_system_error = sticky(state.flags.signaled_system_error,
      set_f.signaled_system_error, clr_f.signaled_system_error);
    next_state.flags.detected_poison_flag = sticky(state.flags.detected_poison_flag,
      set_f.detected_poison_flag, clr_f.detected_poison_flag);
    next_state.int_pend_q = int_pend;

    // Interrupt status: flag set events and pending interrupt onset
    irq_set = '0;
    irq_set[bsr_pkg::IRQ_MASTER_POISON] = set_f.master_poison_flag;
    irq_set[bsr_pkg::IRQ_SYSTEM_ERROR] = set_f.signaled_system_error;
    irq_set[bsr_pkg::IRQ_DETECTED_POISON] = set_f.detected_poison_flag;
    irq_set[bsr_pkg::IRQ_INTERRUPT_PENDING] = int_pend & ~state.int_pend_q;
    irq_clr = '0;
    if (wr_hit && AVS_ADDRESS_I == bsr_pkg::ADDR_IRQ_STATUS && AVS_BYTEENABLE_I[0])
    begin
      irq_clr = AVS_WRITEDATA_I[bsr_pkg::IRQ_W-1:0];
    end
    next_state.irq_status = irq_set | (state.irq_status & ~irq_clr);

    if (wr_hit && AVS_ADDRESS_I == bsr_pkg::ADDR_IRQ_MASK && AVS_BYTEENABLE_I[0])
    begin
      next_state.irq_mask = AVS_WRITEDATA_I[bsr_pkg::IRQ_W-1:0];
    end
    if (wr_hit && AVS_ADDRESS_I == bsr_pkg::ADDR_CONTROL && AVS_BYTEENABLE_I[0])
    begin
      next_state.control = AVS_WRITEDATA_I[2:0];
    end

    // Read data registered; waitrequest drops in the cycle after the request
    next_state.rvalid = 1'b0;
    if (rd_hit || wr_hit)
    begin
      next_state.rvalid = 1'b1;
    end
    if (rd_hit)
    begin
      unique case (AVS_ADDRESS_I)
        bsr_pkg::ADDR_BRIDGE_STATUS: next_state.rdata = {16'h0000, status_view};
        bsr_pkg::ADDR_IRQ_STATUS: next_state.rdata = {28'h0000000, state.irq_status};
        bsr_pkg::ADDR_IRQ_MASK: next_state.rdata = {28'h0000000, state.irq_mask};
        bsr_pkg::ADDR_CONTROL: next_state.rdata = {29'h00000000, state.control};
        default: next_state.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state.flags <= '0;
      state.irq_status <= '0;
      state.irq_mask <= bsr_pkg::RST_IRQ_MASK;
      state.control <= bsr_pkg::RST_CONTROL;
      state.int_pend_q <= 1'b0;
      state.rdata <= 32'h00000000;
      state.rvalid <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~state.rvalid;
  assign AVS_READDATA_O = state.rdata;
  assign PARITY_ERROR_ENABLE_O = state.control[bsr_pkg::POS_PARITY_ERROR_ENABLE];
  assign SYSTEM_ERROR_ENABLE_O = state.control[bsr_pkg::POS_SYSTEM_ERROR_ENABLE];
  assign IRQ_O = |(state.irq_status & state.irq_mask);

endmodule // bsr_status

/* core/bsr_pkg.sv */
// Package for the bridge status register block: offsets, field layout, reset values
package bsr_pkg;

  // Register byte addresses on the Avalon-MM word bus
  localparam logic [3:0] REG_IDX_BRIDGE_STATUS = 4'h6;
  localparam logic [7:0] ADDR_BRIDGE_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
  localparam logic [7:0] ADDR_CONTROL = 8'h28;
  localparam int ADDR_W = 8;

  // Field positions in the bridge status register
  localparam int POS_INTERRUPT_PENDING = 3;
  localparam int POS_CAPABILITY_LIST = 4;
  localparam int POS_MASTER_POISON = 8;
  localparam int POS_SIGNALED_TARGET_ABORT = 11;
  localparam int POS_SIGNALED_SYSTEM_ERROR = 14;
  localparam int POS_DETECTED_POISON = 15;

  // Field positions in the control register
  localparam int POS_PARITY_ERROR_ENABLE = 0;
  localparam int POS_SYSTEM_ERROR_ENABLE = 1;
  localparam int POS_DOWNSTREAM_PORT = 2;

  // Interrupt status and mask bit positions
  localparam int IRQ_MASTER_POISON = 0;
  localparam int IRQ_SYSTEM_ERROR = 1;
  localparam int IRQ_DETECTED_POISON = 2;
  localparam int IRQ_INTERRUPT_PENDING = 3;
  localparam int IRQ_W = 4;

  // Reset values
  localparam logic [2:0] RST_CONTROL = 3'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic [15:0] CONST_BRIDGE_STATUS = 16'h0010;

  // Sticky status flags of the bridge status register
  typedef struct packed {
    logic detected_poison_flag;
    logic signaled_system_error;
    logic master_poison_flag;
  } bsr_flags_t;

  // Events arriving from the primary link and the port logic
  typedef struct packed {
    logic poisoned_tlp_rx;
    logic poisoned_cpl_rx;
    logic poisoned_wr_tx;
    logic err_msg_tx;
    logic hotplug_irq;
    logic internal_parity_err;
    logic cfg_access_err;
  } bsr_events_t;

  // Whole state of the block
  typedef struct packed {
    bsr_flags_t flags;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [2:0] control;
    logic int_pend_q;
    logic [31:0] rdata;
    logic rvalid;
  } bsr_state_t;

endpackage

/* bench/bsr_status_assertions.sv */
// Port checker for the bridge status register block
`timescale 1ns/10ps
module bsr_status_assertions
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [bsr_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire bsr_pkg::bsr_events_t EVENTS_I,
  input wire logic PARITY_ERROR_ENABLE_O,
  input wire logic SYSTEM_ERROR_ENABLE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire logic st = AVS_ADDRESS_I == bsr_pkg::ADDR_BRIDGE_STATUS;
  sequence rd_first;
    AVS_READ_I && AVS_WAITREQUEST_O && st;
  endsequence
  sequence rd_done;
    AVS_READ_I && !AVS_WAITREQUEST_O && st;
  endsequence
  a_wait_first: assert property ($rose(AVS_READ_I) |-> AVS_WAITREQUEST_O)
    else $error("no wait cycle");
  a_wait_end: assert property (AVS_WAITREQUEST_O && AVS_READ_I |=> !AVS_WAITREQUEST_O)
    else $error("wait too long");
  a_cap_one: assert property (rd_done |-> AVS_READDATA_O[4])
    else $error("capability bit low");
  a_rsvd_zero: assert property (rd_done |-> {AVS_READDATA_O[13:12], AVS_READDATA_O[10:9],
    AVS_READDATA_O[7:5], AVS_READDATA_O[2:0]} == 10'h0) else $error("reserved bit set");
  a_tabort_zero: assert property (rd_done |-> !AVS_READDATA_O[11])
    else $error("target abort set");
  a_poison_seen: assert property (EVENTS_I.poisoned_tlp_rx ##1 rd_first |=> AVS_READDATA_O[15])
    else $error("detected poison missing");
  a_master_poison: assert property (PARITY_ERROR_ENABLE_O && EVENTS_I.poisoned_cpl_rx
    ##1 rd_first |=> AVS_READDATA_O[8]) else $error("master poison missing");
  a_syserr_set: assert property (SYSTEM_ERROR_ENABLE_O && EVENTS_I.err_msg_tx
    ##1 rd_first |=> AVS_READDATA_O[14]) else $error("system error missing");
endmodule // bsr_status_assertions

/* bench/bsr_link_model.sv */
// Primary link and port model that raises event pulses and levels
`timescale 1ns/10ps
module bsr_link_model
(
  input wire logic clk_i,
  output bsr_pkg::bsr_events_t events_o
);
  initial events_o = '0;
  task automatic pulse(input bsr_pkg::bsr_events_t e);
    events_o <= e;
    @(posedge clk_i);
    events_o <= '0;
  endtask
  // A level is taken at the next edge and shows in bit 3 from that same edge on
  task automatic hold(input bsr_pkg::bsr_events_t e);
    events_o <= e;
    @(posedge clk_i);
  endtask
endmodule // bsr_link_model

/* bench/testbench.sv */
// Self-checking bench for the bridge status register block
`timescale 1ns/10ps
module testbench;
  logic CLK_I = 0;
  logic RST_I = 1;
  logic [7:0] adr = '0;
  logic rd = 0, wr = 0, fwd = 0;
  logic [31:0] wdat = '0, q, rdat;
  logic [3:0] be = 4'hf;
  logic wt, irq, pe, se;
  bsr_pkg::bsr_events_t ev;
  int bad_count = 0, n_compared = 0, cyc = 0;
  localparam logic [7:0] ST = bsr_pkg::ADDR_BRIDGE_STATUS;
  always #50 CLK_I = ~CLK_I;
  bsr_link_model i_link (.clk_i(CLK_I), .events_o(ev));
  bsr_status i_dut (.CLK_I(CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wt), .EVENTS_I(ev), .FWD_INTX_I(fwd), .PARITY_ERROR_ENABLE_O(pe),
    .SYSTEM_ERROR_ENABLE_O(se), .IRQ_O(irq));
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    // Request stands until the edge at which waitrequest is seen low
    do @(posedge CLK_I); while (wt !== 1'b0);
    q = rdat;
    rd <= 0;
    wr <= 0;
    @(posedge CLK_I);
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    acc(0, a, '0);
    cmp("register", e, q);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge CLK_I)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (2) @(posedge CLK_I);
    RST_I <= 0;
    @(posedge CLK_I);
    chk(ST, 32'h10);
    acc(1, ST, 32'hffff);
    chk(ST, 32'h10);
    chk(8'h2c, 32'h0);
    $display("test reset done");
    i_link.pulse(7'h78);
    chk(ST, 32'h8010);
    acc(1, ST, 32'h0);
    chk(ST, 32'h8010);
    acc(1, 8'h28, 32'h3);
    cmp("enables", 32'h3, {se, pe});
    i_link.pulse(7'h68);
    chk(ST, 32'hc110);
    acc(1, ST, 32'h4000);
    chk(ST, 32'h8110);
    acc(1, ST, 32'h8100);
    i_link.pulse(7'h10);
    chk(ST, 32'h0110);
    fork
      i_link.pulse(7'h40);
      acc(1, ST, 32'hffff);
    join
    chk(ST, 32'h8010);
    be <= 4'h1;
    acc(1, ST, 32'hffff);
    chk(ST, 32'h8010);
    be <= 4'hf;
    acc(1, ST, 32'hffff);
    $display("test flags done");
    acc(1, 8'h20, 32'hf);
    acc(1, 8'h28, 32'h0);
    acc(1, 8'h24, 32'h8);
    fwd <= 1;
    chk(ST, 32'h10);
    i_link.hold(7'h02);
    chk(ST, 32'h18);
    cmp("irq", 32'h1, {31'h0, irq});
    i_link.hold(7'h01);
    chk(ST, 32'h18);
    i_link.hold(7'h00);
    chk(ST, 32'h10);
    chk(8'h20, 32'h8);
    acc(1, 8'h24, 32'h0);
    cmp("irq", 32'h0, {31'h0, irq});
    acc(1, 8'h24, 32'h8);
    acc(1, 8'h20, 32'h8);
    cmp("irq", 32'h0, {31'h0, irq});
    $display("test upstream done");
    acc(1, 8'h28, 32'h4);
    i_link.hold(7'h04);
    chk(ST, 32'h18);
    i_link.hold(7'h00);
    chk(ST, 32'h10);
    $display("test downstream done");
    tally_and_finish;
  end
endmodule // testbench
bind bsr_status bsr_status_assertions i_chk (.CLK_I, .RST_I, .AVS_ADDRESS_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .EVENTS_I, .PARITY_ERROR_ENABLE_O,
  .SYSTEM_ERROR_ENABLE_O);
